// >>> gamma_i2c_pkg.sv
package gamma_i2c_pkg;

    localparam logic [5:0] DEV_ADDR_BASE  = 6'h3A;
    localparam logic [7:0] LAST_REG_PTR   = 8'h2E;
    localparam logic [7:0] PARK_PTR       = 8'hFF;
    localparam logic [7:0] DUMMY_BYTE     = 8'hFF;
    localparam int         PTR_LSB        = 0;
    localparam int         PTR_MSB        = 5;
    localparam int         MEMOP_LSB      = 6;
    localparam int         MEMOP_MSB      = 7;
    localparam logic [1:0] MEMOP_NONE     = 2'h0;
    localparam logic [1:0] MEMOP_LOAD_ONE = 2'h1;
    localparam logic [1:0] MEMOP_LOAD_ALL = 2'h2;
    localparam int         NV_SEL_BIT     = 7;
    localparam int         WORD_END_HI    = 15;
    localparam int         WORD_END_LO    = 14;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_ACK   = 3'b010,
        ST_RX    = 3'b011,
        ST_TX    = 3'b100,
        ST_MACK  = 3'b101,
        ST_SKIP  = 3'b110
    } slave_state_e;

    typedef struct packed {
        logic       valid;
        logic [7:0] ptr;
        logic [15:0] data;
    } word_wr_s;

    typedef struct packed {
        logic       valid;
        logic       all;
        logic [5:0] ptr;
    } memop_req_s;

endpackage

// >>> gamma_ref_i2c_slave_port.sv
`timescale 1ns/10ps
module gamma_ref_i2c_slave_port
    import gamma_i2c_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    input  wire logic        addr_strap_pin_i,
    input  wire logic        store_busy_i,
    input  wire logic [15:0] reg_rdata_i,
    output logic [5:0]       reg_raddr_o,
    output word_wr_s         word_wr_o,
    output logic             nv_commit_o,
    output logic             nv_abort_o,
    output memop_req_s       memop_o
);
    logic [1:0]   scl_sync_ff, sda_sync_ff, strap_sync_ff;
    logic         scl_d_ff, sda_d_ff;
    slave_state_e state_ff;
    logic [7:0]   shift_ff;
    logic [3:0]   bitcnt_ff;
    logic         rd_ff, byte_sel_ff, first_ff, nack_ff, nv_pend_ff;
    logic [7:0]   ptr_ff;
    logic [7:0]   hi_ff;
    logic [7:0]   tx_ff;
    logic         sda_oe_ff;
    word_wr_s     word_wr_ff;
    memop_req_s   memop_ff;
    logic         nv_commit_ff, nv_abort_ff;

    logic scl, sda, scl_rise, scl_fall, start_c, stop_c;
    logic [6:0] my_addr;
    logic [7:0] rx_byte;
    logic [15:0] word_c;
    logic       ptr_valid;

    assign scl      = scl_sync_ff[1];
    assign sda      = sda_sync_ff[1];
    assign scl_rise = scl & ~scl_d_ff;
    assign scl_fall = ~scl & scl_d_ff;
    assign start_c  = scl & scl_d_ff & sda_d_ff & ~sda;
    assign stop_c   = scl & scl_d_ff & ~sda_d_ff & sda;
    assign my_addr  = {DEV_ADDR_BASE, strap_sync_ff[1]};
    assign rx_byte  = {shift_ff[6:0], sda};
    assign word_c   = {hi_ff, rx_byte};
    assign ptr_valid = (ptr_ff <= LAST_REG_PTR);

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
            strap_sync_ff <= 2'h0;
            scl_d_ff    <= 1'b1;
            sda_d_ff    <= 1'b1;
        end else begin
            scl_sync_ff <= {scl_sync_ff[0], scl_i};
            sda_sync_ff <= {sda_sync_ff[0], sda_i};
            strap_sync_ff <= {strap_sync_ff[0], addr_strap_pin_i};
            scl_d_ff    <= scl;
            sda_d_ff    <= sda;
        end
    end

    // protocol engine; bits sampled on rising SCL, SDA changes on falling SCL
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_ff     <= ST_IDLE;
            shift_ff     <= 8'h00;
            bitcnt_ff    <= 4'h0;
            rd_ff        <= 1'b0;
            byte_sel_ff  <= 1'b0;
            first_ff     <= 1'b0;
            nack_ff      <= 1'b0;
            nv_pend_ff   <= 1'b0;
            ptr_ff       <= 8'h00;
            hi_ff        <= 8'h00;
            tx_ff        <= 8'h00;
            sda_oe_ff    <= 1'b0;
            word_wr_ff   <= '0;
            memop_ff     <= '0;
            nv_commit_ff <= 1'b0;
            nv_abort_ff  <= 1'b0;
        end else begin
            word_wr_ff.valid <= 1'b0;
            memop_ff.valid   <= 1'b0;
            nv_commit_ff     <= 1'b0;
            nv_abort_ff      <= 1'b0;
            if (start_c) begin
                state_ff  <= ST_ADDR;
                bitcnt_ff <= 4'h0;
                sda_oe_ff <= 1'b0;
            end else if (stop_c) begin
                state_ff  <= ST_IDLE;
                sda_oe_ff <= 1'b0;
                if (nv_pend_ff) begin
                    nv_abort_ff <= 1'b1;
                end
                nv_pend_ff <= 1'b0;       // pointer kept
            end else if (scl_rise) begin
                case (state_ff)
                    ST_ADDR, ST_RX: begin
                        shift_ff  <= rx_byte;
                        bitcnt_ff <= bitcnt_ff + 4'h1;
                        if (bitcnt_ff == 4'h7) begin
                            // ack slot opens on the following SCL fall
                            nack_ff  <= 1'b1;
                            if (state_ff == ST_ADDR) begin
                                if (rx_byte[7:1] == my_addr && !store_busy_i) begin
                                    nack_ff     <= 1'b0;
                                    rd_ff       <= rx_byte[0];
                                    first_ff    <= ~rx_byte[0];
                                    byte_sel_ff <= 1'b0;
                                end
                            end else if (first_ff) begin
                                nack_ff  <= 1'b0;
                                first_ff <= 1'b0;
                                if (rx_byte[MEMOP_MSB:MEMOP_LSB] == MEMOP_LOAD_ALL ||
                                    rx_byte[MEMOP_MSB:MEMOP_LSB] == MEMOP_LOAD_ONE) begin
                                    memop_ff.valid <= 1'b1;
                                    memop_ff.all   <= rx_byte[MEMOP_MSB];
                                    memop_ff.ptr   <= rx_byte[PTR_MSB:PTR_LSB];
                                end
                                ptr_ff <= {2'h0, rx_byte[PTR_MSB:PTR_LSB]};
                            end else if (!byte_sel_ff) begin
                                hi_ff       <= rx_byte;
                                byte_sel_ff <= 1'b1;
                                nack_ff     <= 1'b0;
                            end else begin
                                byte_sel_ff      <= 1'b0;
                                word_wr_ff.valid <= ptr_valid;
                                word_wr_ff.ptr   <= ptr_ff;
                                word_wr_ff.data  <= word_c;
                                if (hi_ff[NV_SEL_BIT]) begin
                                    nv_pend_ff <= 1'b1;
                                end
                                // end word of a nonvolatile burst: commit and nack
                                if (!word_c[WORD_END_HI] && word_c[WORD_END_LO]) begin
                                    nack_ff      <= 1'b1;
                                    nv_commit_ff <= 1'b1;
                                    nv_pend_ff   <= 1'b0;
                                end else begin
                                    nack_ff <= 1'b0;
                                end
                                ptr_ff <= (ptr_ff >= LAST_REG_PTR) ? PARK_PTR
                                                                    : ptr_ff + 8'h01;
                            end
                        end
                    end
                    ST_TX: begin
                        bitcnt_ff <= bitcnt_ff + 4'h1;
                    end
                    ST_MACK: begin
                        if (sda) begin
                            state_ff <= ST_SKIP;  // master nack ends read
                        end
                    end
                    default: ;
                endcase
            end else if (scl_fall) begin
                case (state_ff)
                    ST_ACK: begin
                        if (nack_ff) begin
                            state_ff <= ST_SKIP;
                        end else if (rd_ff) begin
                            state_ff  <= ST_TX;
                            bitcnt_ff <= 4'h0;
                        end else begin
                            state_ff  <= ST_RX;
                            bitcnt_ff <= 4'h0;
                        end
                        sda_oe_ff <= 1'b0;
                        if (!nack_ff && rd_ff) begin
                            tx_ff <= !ptr_valid ? DUMMY_BYTE
                                   : (byte_sel_ff ? reg_rdata_i[7:0] : reg_rdata_i[15:8]);
                            sda_oe_ff <= !ptr_valid ? 1'b0
                                   : ~(byte_sel_ff ? reg_rdata_i[7] : reg_rdata_i[15]);
                        end
                    end
                    ST_RX, ST_ADDR: begin
                        if (bitcnt_ff == 4'h8) begin
                            state_ff  <= ST_ACK;
                            sda_oe_ff <= ~nack_ff;
                        end
                    end
                    ST_TX: begin
                        if (bitcnt_ff == 4'h8) begin
                            state_ff    <= ST_MACK;
                            sda_oe_ff   <= 1'b0;
                            byte_sel_ff <= ~byte_sel_ff;
                            if (byte_sel_ff && ptr_ff != PARK_PTR) begin
                                ptr_ff <= ptr_ff + 8'h01;
                            end
                        end else begin
                            tx_ff     <= {tx_ff[6:0], 1'b1};
                            sda_oe_ff <= ~tx_ff[6];
                        end
                    end
                    ST_MACK: begin
                        state_ff  <= ST_TX;
                        tx_ff <= !ptr_valid ? DUMMY_BYTE
                               : (byte_sel_ff ? reg_rdata_i[7:0] : reg_rdata_i[15:8]);
                        sda_oe_ff <= !ptr_valid ? 1'b0
                               : ~(byte_sel_ff ? reg_rdata_i[7] : reg_rdata_i[15]);
                        bitcnt_ff <= 4'h0;
                    end
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_raddr_o <= 6'h00;
        end else begin
            reg_raddr_o <= ptr_ff[5:0];
        end
    end

    assign sda_o       = 1'b0;
    assign sda_oe_o    = sda_oe_ff;
    assign word_wr_o   = word_wr_ff;
    assign nv_commit_o = nv_commit_ff;
    assign nv_abort_o  = nv_abort_ff;
    assign memop_o     = memop_ff;

    a_ack_hold: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (state_ff == ST_ACK && !nack_ff && !rd_ff) |-> sda_oe_o || !scl_d_ff)
        else $error("ack not driven during ninth clock");
    a_busy_nack: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (scl_rise && state_ff == ST_ADDR && bitcnt_ff == 4'h7 && store_busy_i) |=> nack_ff)
        else $error("address acked while store busy");
    a_ptr_park: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (word_wr_o.valid && word_wr_o.ptr == LAST_REG_PTR) |-> ptr_ff == PARK_PTR)
        else $error("pointer did not park after last register");
    a_dummy_ones: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (state_ff == ST_TX && !ptr_valid) |-> !sda_oe_o)
        else $error("dummy register not all ones");
    a_end_commit: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        nv_commit_o |-> !nv_pend_ff ##1 !nv_commit_o)
        else $error("commit not single pulse");
    a_stop_keep: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        stop_c |=> ptr_ff == $past(ptr_ff))
        else $error("pointer lost at stop");
    a_addr_match: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (scl_rise && state_ff == ST_ADDR && bitcnt_ff == 4'h7
         && rx_byte[7:1] != my_addr) |=> nack_ff)
        else $error("foreign address acknowledged");
    a_ptr_step: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (word_wr_o.valid && word_wr_o.ptr < LAST_REG_PTR) |-> ptr_ff == word_wr_o.ptr + 8'h01)
        else $error("pointer did not step after word");
endmodule

// >>> i2c_host_model.sv
`timescale 1ns/10ps
module i2c_host_model (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    // bus idles with both lines released high
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // also a repeated start: data is released before clock goes high
    task automatic start_cond();
        tick(5);
        sda_low_o = 1'b0;
        tick(5);
        scl_o = 1'b1;
        tick(10);
        sda_low_o = 1'b1;
        tick(10);
        scl_o = 1'b0;
    endtask

    task automatic stop_cond();
        tick(5);
        sda_low_o = 1'b1;
        tick(5);
        scl_o = 1'b1;
        tick(10);
        sda_low_o = 1'b0;
        tick(10);
    endtask

    // data moves 5 clocks after the fall so the slave's release lands first
    task automatic xfer(input logic b, output logic r);
        tick(5);
        sda_low_o = ~b;
        tick(5);
        scl_o = 1'b1;
        tick(5);
        r = sda_i;
        tick(5);
        scl_o = 1'b0;
    endtask

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer(d[i], r);
        end
        xfer(1'b1, r);
        ack = ~r;
    endtask

    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer(1'b1, d[i]);
        end
        xfer(last, r);
    endtask
endmodule

// >>> gamma_ref_i2c_slave_port_tb.sv
`timescale 1ns/10ps
module gamma_ref_i2c_slave_port_tb;
    import gamma_i2c_pkg::*;
    logic        core_clk_i, nrst_i, strap, busy, scl, sda_low, sda;
    logic        sda_out, sda_oe, commit, abort;
    logic [15:0] rdata;
    logic [5:0]  raddr;
    word_wr_s    word_wr, last_word;
    memop_req_s  memop, last_memop;
    int          n_words = 0, n_commit = 0, n_abort = 0, num_errors = 0, n_checks = 0;

    // pull-up on the wire; either party may pull it low
    assign sda   = ~sda_low & (sda_oe ? sda_out : 1'b1);
    assign rdata = {2'b10, raddr, 2'b01, raddr};

    gamma_ref_i2c_slave_port gamma_ref_i2c_slave_port_i (
        .core_clk_i       (core_clk_i),
        .nrst_i           (nrst_i),
        .scl_i            (scl),
        .sda_i            (sda),
        .sda_o            (sda_out),
        .sda_oe_o         (sda_oe),
        .addr_strap_pin_i (strap),
        .store_busy_i     (busy),
        .reg_rdata_i      (rdata),
        .reg_raddr_o      (raddr),
        .word_wr_o        (word_wr),
        .nv_commit_o      (commit),
        .nv_abort_o       (abort),
        .memop_o          (memop)
    );

    i2c_host_model i2c_host_model_i (
        .clk_i     (core_clk_i),
        .sda_i     (sda),
        .scl_o     (scl),
        .sda_low_o (sda_low)
    );

    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end

    always @(negedge core_clk_i) begin
        if (word_wr.valid === 1'b1) begin
            n_words++;
            last_word = word_wr;
        end
        if (commit === 1'b1) n_commit++;
        if (abort === 1'b1) n_abort++;
        if (memop.valid === 1'b1) last_memop = memop;
    end

    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk_val(input string nm, input logic [24:0] e, input logic [24:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic st();
        i2c_host_model_i.start_cond();
    endtask

    task automatic sp();
        i2c_host_model_i.stop_cond();
    endtask

    task automatic put(input logic [7:0] d, input logic e);
        logic a;
        i2c_host_model_i.wr_byte(d, a);
        chk_bit("ack", e, a);
    endtask

    task automatic get(input logic last, input logic [7:0] e);
        logic [7:0] d;
        i2c_host_model_i.rd_byte(last, d);
        chk_val("rdata", {17'h0, e}, {17'h0, d});
    endtask

    initial begin
        repeat (100000) @(posedge core_clk_i);
        num_errors++;
        end_sim();
    end

    initial begin
        nrst_i = 1'b0;
        strap = 1'b0;
        busy = 1'b0;
        last_memop = '0;
        repeat (12) @(negedge core_clk_i);
        nrst_i = 1'b1;
        repeat (6) @(negedge core_clk_i);
        st();
        put(8'hE8, 1'b1);
        put(8'h05, 1'b1);
        put(8'h12, 1'b1);
        put(8'h34, 1'b1);
        chk_val("word", {1'b1, 8'h05, 16'h1234}, last_word);
        put(8'h36, 1'b1);
        put(8'h78, 1'b1);
        chk_val("word", {1'b1, 8'h06, 16'h3678}, last_word);
        sp();
        st();
        put(8'hE8, 1'b1);
        put(8'h07, 1'b1);
        st();
        put(8'hE9, 1'b1);
        get(1'b0, {2'b10, 6'h07});
        get(1'b0, {2'b01, 6'h07});
        get(1'b0, {2'b10, 6'h08});
        get(1'b1, {2'b01, 6'h08});
        sp();
        st();
        put(8'hE9, 1'b1);
        get(1'b0, {2'b10, 6'h09});
        get(1'b1, {2'b01, 6'h09});
        sp();
        st();
        put(8'hE8, 1'b1);
        put(8'h2D, 1'b1);
        put(8'h2A, 1'b1);
        put(8'h01, 1'b1);
        put(8'h3B, 1'b1);
        put(8'h02, 1'b1);
        chk_val("word", {1'b1, 8'h2E, 16'h3B02}, last_word);
        sp();
        st();
        put(8'hE9, 1'b1);
        get(1'b0, 8'hFF);
        get(1'b0, 8'hFF);
        get(1'b1, 8'hFF);
        sp();
        chk_val("words", 25'd4, n_words[24:0]);
        st();
        put(8'hE8, 1'b1);
        put(8'h03, 1'b1);
        put(8'h80, 1'b1);
        put(8'h11, 1'b1);
        put(8'h40, 1'b1);
        put(8'h22, 1'b0);
        sp();
        chk_val("commit", 25'd1, n_commit[24:0]);
        st();
        put(8'hE8, 1'b1);
        put(8'h03, 1'b1);
        put(8'h80, 1'b1);
        put(8'h11, 1'b1);
        sp();
        chk_val("abort", 25'd1, n_abort[24:0]);
        st();
        put(8'hE8, 1'b1);
        put(8'h85, 1'b1);
        sp();
        chk_val("memop", 25'd3, {23'h0, last_memop.valid, last_memop.all});
        st();
        put(8'hE8, 1'b1);
        put(8'h45, 1'b1);
        sp();
        chk_val("memop", {17'h0, 2'b10, 6'h05}, {17'h0, last_memop});
        busy = 1'b1;
        st();
        put(8'hE8, 1'b0);
        sp();
        busy = 1'b0;
        st();
        put(8'hE8, 1'b1);
        sp();
        st();
        put(8'hEA, 1'b0);
        sp();
        strap = 1'b1;
        st();
        put(8'hEA, 1'b1);
        sp();
        end_sim();
    end
endmodule
